// >>> rdsf_status_flags.sv
// rdsf_status_flags: builds status bits 15, 14, 11..5 and 1 of the receive
// descriptor status word per descriptor, with an AHB-Lite register slave.
// assumes the MAC receive path reports frame events synchronous to clk_in
// and that the descriptor write-back engine consumes desc_wr_out.
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module rdsf_status_flags #(
  parameter int LEN_W = 16
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // AHB-Lite slave
  input  wire logic             hsel_in,
  input  wire logic [31:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic [31:0]           hrdata_out,
  output logic                  hreadyout_out,
  output logic                  hresp_out,
  // receive path events
  input  wire logic             frame_start_in,
  input  wire logic             rx_byte_in,
  input  wire logic             dest_mcast_in,
  input  wire logic [15:0]      len_type_in,
  input  wire logic             len_type_vld_in,
  input  wire logic             late_coll_in,
  input  wire logic             crc_err_in,
  input  wire logic             frame_end_in,
  // descriptor buffer sizing from descriptor fetch
  input  wire logic             desc_load_in,
  input  wire logic [10:0]      buf1_size_in,
  input  wire logic [10:0]      buf2_size_in,
  input  wire logic             desc_full_in,
  input  wire logic             desc_trunc_in,
  // descriptor write-back
  output logic                  desc_wr_out,
  output logic [31:0]           desc_status_out,
  output logic                  desc_own_release_out,
  output logic                  frame_drop_out,
  output logic                  irq_out
);
  import rdsf_pkg::*;

  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_RECV, S_WRITE, S_RELEASE} rdsf_state_t;
  rdsf_state_t state_r;

  logic [LEN_W-1:0] len_r;
  logic             pass_bad_r;
  logic             vlan_en_r;
  logic             mcast_r;
  logic             coll_r;
  logic             crc_r;
  logic             ftype_r;
  logic             first_pending_r;
  logic             de_r;
  logic [31:0]      word_r;
  logic [31:0]      last_word_r;
  logic             buf_has_room;

  // a descriptor whose two buffers are both empty cannot hold frame data
  assign buf_has_room = (buf1_size_in != 11'h000) || (buf2_size_in != 11'h000);

  logic [LEN_W-1:0] max_len;
  assign max_len = vlan_en_r ? LEN_W'(MAX_LEN_VLAN) : LEN_W'(MAX_LEN_PLAIN);

  logic runt, too_long;
  assign runt     = (len_r < LEN_W'(COLL_WINDOW_BYTES));
  assign too_long = (len_r > max_len);

  // assemble one descriptor's status; last = frame ends in this descriptor
  function automatic logic [31:0] build_word(input logic last, input logic first);
    logic [31:0] w;
    w          = RESET_WORD;
    w[BIT_FIRST] = first;
    w[BIT_LAST]  = last;
    w[BIT_MCAST] = mcast_r;
    w[BIT_CS]    = coll_r;
    w[BIT_FTYPE] = ftype_r;
    w[BIT_CE]    = last & crc_r;
    w[BIT_RUNT]  = last & runt;
    w[BIT_LONG]  = last & too_long;
    w[BIT_DE]    = last & de_r;
    w[BIT_ERR_SUM] = w[BIT_CE] | w[BIT_CS] | w[BIT_LONG] | w[BIT_RUNT] | w[BIT_DE];
    return w;
  endfunction : build_word

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE:    if (frame_start_in) state_r <= S_RECV;
        S_RECV:    if (frame_end_in || desc_trunc_in) state_r <= S_WRITE;
        S_WRITE:   state_r <= S_RELEASE;
        S_RELEASE: state_r <= S_IDLE;
      endcase
    end
  end

  // length counts every byte and holds at all ones; nothing here cuts a long frame short
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      len_r <= '0;
    end else if (state_r == S_IDLE && frame_start_in) begin
      len_r <= '0;
    end else if (state_r == S_RECV && rx_byte_in && len_r != '1) begin
      len_r <= len_r + LEN_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mcast_r <= 1'b0;
      coll_r  <= 1'b0;
      crc_r   <= 1'b0;
      ftype_r <= 1'b0;
      de_r    <= 1'b0;
    end else if (state_r == S_IDLE && frame_start_in) begin
      mcast_r <= dest_mcast_in;
      coll_r  <= 1'b0;
      crc_r   <= 1'b0;
      ftype_r <= 1'b0;
      de_r    <= 1'b0;
    end else if (state_r == S_RECV) begin
      if (late_coll_in && len_r >= LEN_W'(COLL_WINDOW_BYTES)) coll_r <= 1'b1;
      if (crc_err_in) crc_r <= 1'b1;
      if (desc_trunc_in) de_r <= 1'b1;
      // the flag updates only on len_type_vld_in; the byte count is not checked against 14 here
      if (len_type_vld_in) ftype_r <= (len_type_in >= ETHERTYPE_MIN);
    end
  end

  // first flag goes to the first descriptor that really holds data
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      first_pending_r <= 1'b0;
    end else if (state_r == S_IDLE && frame_start_in) begin
      first_pending_r <= 1'b1;
    end else if (desc_wr_out && desc_status_out[BIT_FIRST]) begin
      first_pending_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // descriptor write-back
  // ----------------------------------------
  logic drop_now;
  assign drop_now = runt && !pass_bad_r;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      desc_wr_out          <= 1'b0;
      desc_status_out      <= RESET_WORD;
      desc_own_release_out <= 1'b0;
      frame_drop_out       <= 1'b0;
      last_word_r          <= RESET_WORD;
    end else begin
      desc_wr_out          <= 1'b0;
      desc_own_release_out <= 1'b0;
      frame_drop_out       <= 1'b0;
      if (state_r == S_RECV && desc_full_in && !frame_end_in && desc_load_in) begin
        // intermediate descriptor: status written before ownership goes back
        desc_wr_out     <= buf_has_room;
        desc_status_out <= build_word(1'b0, first_pending_r && buf_has_room);
      end else if (state_r == S_WRITE) begin
        if (drop_now) begin
          frame_drop_out <= 1'b1;
        end else begin
          desc_wr_out     <= 1'b1;
          desc_status_out <= build_word(1'b1, first_pending_r);
          last_word_r     <= build_word(1'b1, first_pending_r);
        end
      end else if (state_r == S_RELEASE) begin
        desc_own_release_out <= !frame_drop_out;
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_DONE] = desc_own_release_out;
    irq_set[IRQ_RUNT] = desc_wr_out && desc_status_out[BIT_RUNT];
    irq_set[IRQ_DROP] = frame_drop_out;
    irq_set[IRQ_ERR]  = desc_wr_out && desc_status_out[BIT_ERR_SUM];
  end

  // set wins over a simultaneous write-one-to-clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  logic       dp_wr_r;
  logic       dp_rd_r;
  logic [7:0] dp_addr_r;
  logic       ap_take;

  assign ap_take = hsel_in && hready_in && htrans_in[1];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hready_in) begin
      dp_wr_r   <= ap_take && hwrite_in;
      dp_rd_r   <= ap_take && !hwrite_in;
      dp_addr_r <= haddr_in[7:0];
    end
  end

  assign irq_clr = (dp_wr_r && dp_addr_r == ADDR_IRQ) ? hwdata_in[IRQ_W-1:0] : '0;

  // flags are never software settable; irq flags clear by write-one at ADDR_IRQ, control and mask take written values
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pass_bad_r <= 1'b0;
      vlan_en_r  <= 1'b0;
      irq_mask_r <= '0;
    end else if (dp_wr_r) begin
      if (dp_addr_r == ADDR_CTRL) begin
        pass_bad_r <= hwdata_in[CTRL_PASS_BAD];
        vlan_en_r  <= hwdata_in[CTRL_VLAN];
      end
      if (dp_addr_r == ADDR_MASK) irq_mask_r <= hwdata_in[IRQ_W-1:0];
    end
  end

  always_comb begin
    word_r = 32'h0000_0000;
    unique case (haddr_in[7:0])
      ADDR_CTRL:   word_r = {30'h0, vlan_en_r, pass_bad_r};
      ADDR_STATUS: word_r = {28'h0, ftype_r, mcast_r, 1'b0, state_r != S_IDLE};
      ADDR_IRQ:    word_r = {{(32-IRQ_W){1'b0}}, irq_stat_r};
      ADDR_MASK:   word_r = {{(32-IRQ_W){1'b0}}, irq_mask_r};
      ADDR_LAST:   word_r = last_word_r;
      default:     word_r = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (ap_take && !hwrite_in) begin
      hrdata_out <= word_r;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hreadyout_out <= 1'b0;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

endmodule : rdsf_status_flags

// >>> rdsf_pkg.sv
// rdsf_pkg: constants for the receive descriptor status flag builder
// assumes a single 40 MHz system clock domain
package rdsf_pkg;

  // ----------------------------------------
  // status word bit positions
  // ----------------------------------------
  localparam int BIT_ERR_SUM = 15;
  localparam int BIT_DE      = 14;
  localparam int BIT_RUNT    = 11;
  localparam int BIT_MCAST   = 10;
  localparam int BIT_FIRST   = 9;
  localparam int BIT_LAST    = 8;
  localparam int BIT_LONG    = 7;
  localparam int BIT_CS      = 6;
  localparam int BIT_FTYPE   = 5;
  localparam int BIT_CE      = 1;

  // ----------------------------------------
  // frame size limits (bytes)
  // ----------------------------------------
  localparam logic [15:0] COLL_WINDOW_BYTES = 16'h0040;  // 64
  localparam logic [15:0] MAX_LEN_PLAIN     = 16'h05ee;  // 1518
  localparam logic [15:0] MAX_LEN_VLAN      = 16'h05f2;  // 1522
  localparam logic [15:0] ETHERTYPE_MIN     = 16'h0600;  // 1536
  localparam logic [15:0] LEN_TYPE_END      = 16'h000e;  // 14

  // ----------------------------------------
  // register map (AHB-Lite byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ    = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_LAST   = 8'h10;

  localparam int CTRL_PASS_BAD = 0;
  localparam int CTRL_VLAN     = 1;

  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RUNT = 1;
  localparam int IRQ_DROP = 2;
  localparam int IRQ_ERR  = 3;
  localparam int IRQ_W    = 4;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage : rdsf_pkg

// >>> rdsf_host_model.sv
// rdsf_host_model: host side that reads back descriptor status words
// assumes write-back pulses are synchronous to clk_in
`timescale 1ns/1ps
module rdsf_host_model (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        desc_wr_in,
  input  wire logic [31:0] desc_status_in,
  input  wire logic        own_release_in,
  output logic      [31:0] first_word_out,
  output logic      [31:0] last_word_out
);
  logic got_r;
  // host only reads; tl and ft validity are judged by the bench
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      got_r          <= 1'h0;
      first_word_out <= 32'h0;
      last_word_out  <= 32'h0;
    end else if (desc_wr_in) begin
      got_r         <= 1'h1;
      last_word_out <= desc_status_in;
      if (!got_r) first_word_out <= desc_status_in;
    end else if (own_release_in) begin
      got_r <= 1'h0;
    end
  end
endmodule : rdsf_host_model

// >>> rdsf_status_flags_monitor.sv
// rdsf_status_flags_monitor: assertions on descriptor status write-back
// assumes one clock domain; bound to every rdsf_status_flags instance
`timescale 1ns/1ps
module rdsf_status_flags_monitor
  import rdsf_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        frame_start_in,
  input wire logic        rx_byte_in,
  input wire logic        dest_mcast_in,
  input wire logic [15:0] len_type_in,
  input wire logic        len_type_vld_in,
  input wire logic        late_coll_in,
  input wire logic        frame_end_in,
  input wire logic        desc_trunc_in,
  input wire logic        desc_wr_out,
  input wire logic [31:0] desc_status_out,
  input wire logic        desc_own_release_out,
  input wire logic        frame_drop_out
);
  logic        in_r, mc_r, first_r, lc_r, typ_r;
  logic [15:0] cnt_r;
  wire  [31:0] s  = desc_status_out;
  wire         wl = desc_wr_out && s[BIT_LAST];
  // shadow of the frame in flight; saturates like the design
  // a start in the release cycle is taken, as the design is idle again then
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {in_r, mc_r, first_r, lc_r, typ_r} <= 5'h0;
      cnt_r <= 16'h0;
    end else if (frame_start_in && (!in_r || desc_own_release_out)) begin
      {in_r, mc_r, first_r, lc_r, typ_r} <= {1'h1, dest_mcast_in, 3'h4};
      cnt_r <= 16'h0;
    end else begin
      if (rx_byte_in && cnt_r != 16'hffff) cnt_r <= cnt_r + 16'h1;
      if (late_coll_in && cnt_r >= COLL_WINDOW_BYTES) lc_r <= 1'h1;
      if (len_type_vld_in) typ_r <= len_type_in >= ETHERTYPE_MIN;
      if (desc_wr_out) first_r <= 1'h0;
      if (desc_own_release_out || frame_drop_out) in_r <= 1'h0;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  a_err_summary: assert property (desc_wr_out |-> s[BIT_ERR_SUM] ==
    (s[BIT_CE] | s[BIT_CS] | s[BIT_LONG] | s[BIT_RUNT] | s[BIT_DE])) else $error("summary wrong");
  a_runt_flag: assert property (wl |-> s[BIT_RUNT] == (cnt_r < COLL_WINDOW_BYTES))
    else $error("runt flag wrong");
  a_drop_runt: assert property (frame_drop_out |-> cnt_r < COLL_WINDOW_BYTES && !desc_wr_out)
    else $error("drop of non-runt");
  a_mcast_flag: assert property (wl |-> s[BIT_MCAST] == mc_r) else $error("mcast wrong");
  a_first_flag: assert property (desc_wr_out |-> s[BIT_FIRST] == first_r)
    else $error("first wrong");
  a_tl_in_last: assert property (desc_wr_out && s[BIT_LONG] |-> s[BIT_LAST])
    else $error("too long outside last");
  a_late_coll: assert property (wl |-> s[BIT_CS] == lc_r) else $error("collision wrong");
  a_frame_type: assert property (wl |-> s[BIT_FTYPE] == typ_r) else $error("type wrong");
  a_end_to_wr: assert property (in_r && (frame_end_in || desc_trunc_in) |-> ##2
    (desc_wr_out || frame_drop_out)) else $error("no write-back");
  a_own_after: assert property (desc_own_release_out |-> $past(wl))
    else $error("release without last write");
endmodule : rdsf_status_flags_monitor
bind rdsf_status_flags rdsf_status_flags_monitor u_mon (.clk_in, .resetn_in, .frame_start_in,
  .rx_byte_in, .dest_mcast_in, .len_type_in, .len_type_vld_in, .late_coll_in, .frame_end_in,
  .desc_trunc_in, .desc_wr_out, .desc_status_out, .desc_own_release_out, .frame_drop_out);

// >>> rdsf_status_flags_tb.sv
// rdsf_status_flags_tb: self-checking bench for the status flag builder
// assumes a single slave on the bus and the host model as write-back sink
`timescale 1ns/1ps
module rdsf_status_flags_tb;
  import rdsf_pkg::*;
  logic        clk_in = 1'h0, resetn_in = 1'h0, hsel_in = 1'h0, hwrite_in = 1'h0;
  logic        frame_start_in = 1'h0, rx_byte_in = 1'h0, dest_mcast_in = 1'h0;
  logic        len_type_vld_in = 1'h0, late_coll_in = 1'h0, frame_end_in = 1'h0;
  logic        desc_load_in = 1'h0, desc_full_in = 1'h0, drop;
  logic        crc_err_in = 1'h0, desc_trunc_in = 1'h0;
  logic        hreadyout_out, hresp_out, desc_wr_out, desc_own_release_out;
  logic        frame_drop_out, irq_out;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, desc_status_out, fw, lw, rd;
  logic [15:0] len_type_in = 16'h0;
  logic [10:0] buf1_size_in = 11'h0, buf2_size_in = 11'h0;
  logic [2:0]  hsize_in = 3'h2;
  logic [1:0]  htrans_in = 2'h0;
  wire         hready_in = hreadyout_out;
  int          err_count = 0, samples_checked = 0;
  always #12.5 clk_in = ~clk_in;
  rdsf_status_flags DUT (.clk_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .frame_start_in, .rx_byte_in, .dest_mcast_in, .len_type_in, .len_type_vld_in,
    .late_coll_in, .crc_err_in, .frame_end_in, .desc_load_in, .buf1_size_in,
    .buf2_size_in, .desc_full_in, .desc_trunc_in, .desc_wr_out, .desc_status_out,
    .desc_own_release_out, .frame_drop_out, .irq_out);
  rdsf_host_model u_host (.clk_in, .resetn_in, .desc_wr_in(desc_wr_out),
    .desc_status_in(desc_status_out), .own_release_in(desc_own_release_out),
    .first_word_out(fw), .last_word_out(lw));
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // a lost handshake ends the run rather than hanging it
  task wait_rdy;
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (hreadyout_out === 1'h1) break;
    end
    if (k == 50) begin
      err_count++;
      stop_test();
    end
  endtask : wait_rdy
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    {hsel_in, htrans_in, hwrite_in, haddr_in} <= {1'h1, 2'h2, wr, 24'h0, a};
    wait_rdy();
    {hsel_in, htrans_in, hwdata_in} <= {3'h0, wd};
    wait_rdy();
    rd = hrdata_out;
  endtask : ahb
  // er[0] raises a crc error, er[1] ends the frame by a descriptor error
  task frame(input int n, input logic mc, input logic [15:0] lt, input logic lc, input logic sp,
             input logic [1:0] er);
    int i;
    @(posedge clk_in);
    {frame_start_in, dest_mcast_in} <= {1'h1, mc};
    buf1_size_in <= 11'h1 + 11'($urandom % 2000);
    buf2_size_in <= 11'h1 + 11'($urandom % 2000);
    @(posedge clk_in);
    {frame_start_in, rx_byte_in} <= 2'h1;
    for (i = 0; i < n; i++) begin
      @(posedge clk_in);
      {desc_load_in, desc_full_in} <= {2{sp && i == 19}};
    end
    {rx_byte_in, len_type_in, len_type_vld_in, late_coll_in} <= {1'h0, lt, n >= 14, lc};
    crc_err_in <= er[0];
    @(posedge clk_in);
    {len_type_vld_in, late_coll_in, crc_err_in} <= 3'h0;
    {frame_end_in, desc_trunc_in} <= {!er[1], er[1]};
    @(posedge clk_in);
    {frame_end_in, desc_trunc_in} <= 2'h0;
    drop = 1'h0;
    for (i = 0; i < 8; i++) begin
      @(negedge clk_in);
      drop |= frame_drop_out;
      if (desc_own_release_out || frame_drop_out) break;
    end
    if (i == 8) begin
      err_count++;
      stop_test();
    end
  endtask : frame
  function automatic logic [31:0] exp_st(int n, logic mc, logic [15:0] lt, logic lc, logic vl,
                                         logic [1:0] er);
    logic [31:0] e;
    e = 32'h100;
    e[BIT_RUNT]  = n < 64;
    e[BIT_MCAST] = mc;
    e[BIT_LONG]  = n > (vl ? 1522 : 1518);
    e[BIT_CS]    = lc && n >= 64;
    e[BIT_FTYPE] = n >= 14 && lt >= 16'h0600;
    e[BIT_CE]    = er[0];
    e[BIT_DE]    = er[1];
    e[BIT_ERR_SUM] = e[BIT_RUNT] | e[BIT_LONG] | e[BIT_CS] | e[BIT_CE] | e[BIT_DE];
    return e;
  endfunction : exp_st
  initial begin
    int i, n, lens[8];
    logic mc, lc, vl, sp;
    logic [1:0] er;
    logic [15:0] lt;
    lens = '{13, 63, 64, 1518, 1519, 1522, 1523, 200};
    void'($urandom(50));
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    ahb(1'h1, 8'h14, 32'hffffffff);
    for (i = 0; i < 6; i++) begin
      ahb(1'h0, 8'(i * 4), 32'h0);
      chk(rd, RESET_WORD);
    end
    chk({31'h0, hresp_out}, 32'h0);
    frame(20, 1'h0, 16'h0800, 1'h0, 1'h0, 2'h0);
    chk({drop, irq_out}, 32'h2);
    ahb(1'h1, ADDR_MASK, 32'h4);
    // mask lands at the data-phase edge, the output one clock later
    repeat (2) @(negedge clk_in);
    chk(irq_out, 32'h1);
    ahb(1'h0, ADDR_IRQ, 32'h0);
    chk(rd & 32'h4, 32'h4);
    ahb(1'h1, ADDR_IRQ, 32'h4);
    @(negedge clk_in);
    chk(irq_out, 32'h0);
    for (i = 0; i < 16; i++) begin
      n = i < 8 ? lens[i] : 14 + $urandom % 1600;
      lt = i < 8 ? (i[0] ? 16'h0600 : 16'h05ff) : 16'($urandom);
      vl = n > 1520 || (i >= 8 && $urandom % 2);
      mc = $urandom % 2;
      lc = i % 3 != 2;
      sp = n > 40 && i[1];
      er = {i % 5 == 4, i % 4 == 1};
      ahb(1'h1, ADDR_CTRL, {30'h0, vl, 1'h1});
      frame(n, mc, lt, lc, sp, er);
      chk({drop, lw[15:0] & 16'hcfe2},
        exp_st(n, mc, lt, lc, vl, er) | {22'h0, !sp, 9'h0});
      if (sp) chk(fw & 32'h300, 32'h200);
    end
    stop_test();
  end
endmodule : rdsf_status_flags_tb
